// [hw/dmrs_top.sv]
// Request, mask and terminal-count status logic for two cascaded
// four-channel DMA controllers, first_controller on channels 0-3
// and second_controller on channels 4-7.
// Assumes tc, autoinit and block-timeout inputs come from the same
// clock; request pins are asynchronous and are synchronised here.
//
// Summary of operation
// - Request write sets selected software request when bit 2 is 1, else clears.
// - Software request acts like a hardware request, unmaskable, still arbitrated.
// - Terminal count on a channel clears its software request bit.
// - Reset or master clear clears all software requests; bus reset drive does not.
// - Data bits 1:0 select channel 0-3 or 4-7 for request and mask writes.
// - Single-mask write bit 2 sets or clears the selected channel mask.
// - Terminal count sets the channel mask unless autoinitialization is on.
// - Reset or master clear sets all mask bits, blocking hardware requests.
// - Channel 4 mask also blocks requests on channels 0 to 3.
// - All-mask write loads four mask bits from data bits 3:0.
// - All-mask read returns current four mask bits on bits 3:0.
// - Terminal count sets that channel's status flag in bits 3:0.
// - Terminal-count flags clear on reset and on each read of their own controller's status.
// - Status bits 7:4 show live pending requests of channels 0-3 or 4-7.
// - Channel 4 is cascade only; its status bits may read any value.
// - All-mask write setting channel 4 mask blocks first controller requests.
`include "dmrs_regs.svh"

module dmrs_top (
	input  wire logic             clk_sys_in,
	input  wire logic             rst_b_in,
	input  wire logic             clk_en_in,
	input  wire logic [7:0]       addr_in,
	input  wire logic [7:0]       wdata_in,
	input  wire logic             wr_in,
	input  wire logic             rd_in,
	output logic      [7:0]       rdata_out,
	input  wire logic             master_clear_in,
	input  wire logic [7:0]       dreq_in,
	input  wire logic [7:0]       blk_timeout_in,
	input  wire logic [7:0]       tc_in,
	input  wire logic [7:0]       autoinit_in,
	output logic      [7:0]       req_out,
	output logic                  irq_out
);

	// ==========================================================
	// Helpers

	// One-hot of a channel select field
	function automatic dmrs_pkg::dmrs_nib_t dmrs_onehot(
		input dmrs_pkg::dmrs_sel_t sel
	);
		dmrs_onehot = 4'h1 << sel;
	endfunction : dmrs_onehot

	// Set or clear one selected bit of a controller's nibble
	function automatic dmrs_pkg::dmrs_nib_t dmrs_upd(
		input dmrs_pkg::dmrs_nib_t cur,
		input dmrs_pkg::dmrs_byte_t wd
	);
		dmrs_pkg::dmrs_nib_t oh;
		oh = dmrs_onehot(wd[`DMRS_SEL_MSB:`DMRS_SEL_LSB]);
		dmrs_upd = wd[`DMRS_SET_BIT] ? (cur | oh) : (cur & ~oh);
	endfunction : dmrs_upd

	// ==========================================================
	// Request pin synchroniser

	logic [7:0] dreq_meta_q;
	logic [7:0] dreq_meta_d;
	logic [7:0] dreq_sync_q;
	logic [7:0] dreq_sync_d;

	// First stage feeds only the second stage
	always_comb begin
		dreq_meta_d = dreq_in;
		dreq_sync_d = dreq_meta_q;
	end

	always_ff @(posedge clk_sys_in) begin
		if (!rst_b_in) begin
			dreq_meta_q <= 8'h00;
			dreq_sync_q <= 8'h00;
		end else if (clk_en_in) begin
			dreq_meta_q <= dreq_meta_d;
			dreq_sync_q <= dreq_sync_d;
		end
	end

	// ==========================================================
	// Access decode

	logic wr_req1;
	logic wr_req2;
	logic wr_smsk1;
	logic wr_smsk2;
	logic wr_amsk1;
	logic wr_amsk2;
	logic wr_ist;
	logic wr_imsk;
	logic rd_stat1;
	logic rd_stat2;
	logic rd_acc;

	// Strobes only count while the clock enable is high
	assign wr_req1  = clk_en_in & wr_in & (addr_in == `DMRS_OFF_REQ1);
	assign wr_req2  = clk_en_in & wr_in & (addr_in == `DMRS_OFF_REQ2);
	assign wr_smsk1 = clk_en_in & wr_in & (addr_in == `DMRS_OFF_SMSK1);
	assign wr_smsk2 = clk_en_in & wr_in & (addr_in == `DMRS_OFF_SMSK2);
	assign wr_amsk1 = clk_en_in & wr_in & (addr_in == `DMRS_OFF_AMSK1);
	assign wr_amsk2 = clk_en_in & wr_in & (addr_in == `DMRS_OFF_AMSK2);
	assign wr_ist   = clk_en_in & wr_in & (addr_in == `DMRS_OFF_IST);
	assign wr_imsk  = clk_en_in & wr_in & (addr_in == `DMRS_OFF_IMSK);
	assign rd_acc   = clk_en_in & rd_in;
	assign rd_stat1 = rd_acc & (addr_in == `DMRS_OFF_STAT1);
	assign rd_stat2 = rd_acc & (addr_in == `DMRS_OFF_STAT2);

	// ==========================================================
	// Software requests

	logic [7:0] swr_q;
	logic [7:0] swr_d;

	// Write beats a same-cycle terminal count; bus reset drive is
	// not an input here, so it cannot disturb these bits
	always_comb begin
		swr_d = swr_q & ~tc_in;
		if (wr_req1) begin
			swr_d[3:0] = dmrs_upd(swr_q[3:0], wdata_in);
		end
		if (wr_req2) begin
			swr_d[7:4] = dmrs_upd(swr_q[7:4], wdata_in);
		end
		if (master_clear_in) begin
			swr_d = `DMRS_SWR_RST;
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (!rst_b_in) begin
			swr_q <= `DMRS_SWR_RST;
		end else if (clk_en_in) begin
			swr_q <= swr_d;
		end
	end

	// ==========================================================
	// Mask bits

	logic [7:0] mask_q;
	logic [7:0] mask_d;
	logic [7:0] tc_mask_set;

	assign tc_mask_set = tc_in & ~autoinit_in;

	// Hardware set from terminal count wins over a software clear
	always_comb begin
		mask_d = mask_q;
		if (wr_smsk1) begin
			mask_d[3:0] = dmrs_upd(mask_q[3:0], wdata_in);
		end
		if (wr_smsk2) begin
			mask_d[7:4] = dmrs_upd(mask_q[7:4], wdata_in);
		end
		if (wr_amsk1) begin
			mask_d[3:0] = wdata_in[3:0];
		end
		if (wr_amsk2) begin
			mask_d[7:4] = wdata_in[3:0];
		end
		mask_d = mask_d | tc_mask_set;
		if (master_clear_in) begin
			mask_d = `DMRS_MASK_RST;
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (!rst_b_in) begin
			mask_q <= `DMRS_MASK_RST;
		end else if (clk_en_in) begin
			mask_q <= mask_d;
		end
	end

	// ==========================================================
	// Request gating toward arbitration

	logic [7:0] hw_req;
	logic [7:0] eff_mask;
	logic [7:0] pend;

	// Channel 4 mask covers the whole first controller
	assign eff_mask = {mask_q[7:4], mask_q[3:0] | {4{mask_q[4]}}};
	assign hw_req   = dreq_sync_q | blk_timeout_in;
	assign pend     = hw_req | swr_q;

	// Channel 4 carries no pins; it mirrors the cascaded group, and a
	// software request on it must still reach arbitration unmasked
	always_comb begin
		req_out    = (hw_req & ~eff_mask) | swr_q;
		req_out[4] = (|req_out[3:0]) | swr_q[4];
	end

	// ==========================================================
	// Terminal-count status flags

	logic [7:0] tcs_q;
	logic [7:0] tcs_d;

	// A terminal count landing on the read cycle survives the clear
	always_comb begin
		tcs_d = tcs_q;
		if (rd_stat1) begin
			tcs_d[3:0] = 4'h0;
		end
		if (rd_stat2) begin
			tcs_d[7:4] = 4'h0;
		end
		tcs_d = tcs_d | tc_in;
	end

	always_ff @(posedge clk_sys_in) begin
		if (!rst_b_in) begin
			tcs_q <= `DMRS_TCS_RST;
		end else if (clk_en_in) begin
			tcs_q <= tcs_d;
		end
	end

	// ==========================================================
	// Interrupt status and mask

	logic [7:0] ist_q;
	logic [7:0] ist_d;
	logic [7:0] imsk_q;
	logic [7:0] imsk_d;

	// Write one to clear; a new terminal count wins
	always_comb begin
		ist_d  = ist_q;
		imsk_d = imsk_q;
		if (wr_ist) begin
			ist_d = ist_q & ~wdata_in;
		end
		ist_d = ist_d | tc_in;
		if (wr_imsk) begin
			imsk_d = wdata_in;
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (!rst_b_in) begin
			ist_q  <= `DMRS_IST_RST;
			imsk_q <= `DMRS_IMSK_RST;
		end else if (clk_en_in) begin
			ist_q  <= ist_d;
			imsk_q <= imsk_d;
		end
	end

	assign irq_out = |(ist_q & imsk_q);

	// ==========================================================
	// Read data

	logic [7:0] rdata_q;
	logic [7:0] rdata_d;

	// Data stand only in the cycle after the strobe
	always_comb begin
		rdata_d = `DMRS_RD_IDLE;
		if (rd_acc) begin
			unique case (addr_in)
				`DMRS_OFF_STAT1: rdata_d = {pend[3:0], tcs_q[3:0]};
				`DMRS_OFF_STAT2: rdata_d = {pend[7:4], tcs_q[7:4]};
				`DMRS_OFF_AMSK1: rdata_d = {4'h0, mask_q[3:0]};
				`DMRS_OFF_AMSK2: rdata_d = {4'h0, mask_q[7:4]};
				`DMRS_OFF_IST:   rdata_d = ist_q;
				`DMRS_OFF_IMSK:  rdata_d = imsk_q;
				default:         rdata_d = `DMRS_RD_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (!rst_b_in) begin
			rdata_q <= `DMRS_RD_IDLE;
		end else if (clk_en_in) begin
			rdata_q <= rdata_d;
		end
	end

	assign rdata_out = rdata_q;

	// ==========================================================
	// Assertions

	default clocking dmrs_cb @(posedge clk_sys_in); endclocking
	default disable iff (!rst_b_in);

	logic quiet;
	assign quiet = clk_en_in & ~master_clear_in;

	property p_swr_write;
		quiet & wr_req1 |=>
			swr_q[{1'b0, $past(wdata_in[1:0])}] == $past(wdata_in[2]);
	endproperty
	a_swr_write: assert property (p_swr_write)
		else $error("software request write not applied");

	property p_swr_tc;
		quiet & ~wr_req1 & ~wr_req2 |=>
			(swr_q & $past(tc_in)) == 8'h00;
	endproperty
	a_swr_tc: assert property (p_swr_tc)
		else $error("software request survived terminal count");

	property p_clear_cmd;
		clk_en_in & master_clear_in |=>
			swr_q == 8'h00 && mask_q == 8'hFF;
	endproperty
	a_clear_cmd: assert property (p_clear_cmd)
		else $error("master clear did not initialise state");

	property p_reset_mask;
		$rose(rst_b_in) |-> mask_q == 8'hFF && swr_q == 8'h00;
	endproperty
	a_reset_mask: assert property (p_reset_mask)
		else $error("masks not set after reset");

	property p_swr_pass;
		(req_out & swr_q) == swr_q;
	endproperty
	a_swr_pass: assert property (p_swr_pass)
		else $error("software request was masked");

	property p_single_mask;
		quiet & wr_smsk2 & (tc_in == 8'h00) |=>
			mask_q[{1'b1, $past(wdata_in[1:0])}] == $past(wdata_in[2]);
	endproperty
	a_single_mask: assert property (p_single_mask)
		else $error("single mask write not applied");

	property p_tc_mask;
		quiet |=> (mask_q & $past(tc_mask_set)) == $past(tc_mask_set);
	endproperty
	a_tc_mask: assert property (p_tc_mask)
		else $error("terminal count did not mask channel");

	property p_cascade;
		mask_q[4] |-> (req_out[3:0] & ~swr_q[3:0]) == 4'h0;
	endproperty
	a_cascade: assert property (p_cascade)
		else $error("cascade mask did not block first controller");

	property p_all_mask;
		quiet & wr_amsk1 & (tc_in == 8'h00) |=>
			mask_q[3:0] == $past(wdata_in[3:0]);
	endproperty
	a_all_mask: assert property (p_all_mask)
		else $error("all mask write not loaded");

	property p_mask_read;
		rd_acc & (addr_in == `DMRS_OFF_AMSK2) |=>
			rdata_out == {4'h0, $past(mask_q[7:4])};
	endproperty
	a_mask_read: assert property (p_mask_read)
		else $error("mask read returned wrong value");

	property p_tc_read;
		rd_stat1 |=> tcs_q[3:0] == $past(tc_in[3:0]);
	endproperty
	a_tc_read: assert property (p_tc_read)
		else $error("status read did not clear flags");

	property p_tc_flag;
		clk_en_in |=> (tcs_q & $past(tc_in)) == $past(tc_in);
	endproperty
	a_tc_flag: assert property (p_tc_flag)
		else $error("terminal count flag not set");

	property p_pend_read;
		rd_stat1 |=> rdata_out[7:4] == $past(pend[3:0]);
	endproperty
	a_pend_read: assert property (p_pend_read)
		else $error("pending status wrong");

	property p_hw_gate;
		(req_out & ~swr_q & eff_mask & 8'hEF) == 8'h00;
	endproperty
	a_hw_gate: assert property (p_hw_gate)
		else $error("masked hardware request passed");

	c_sw_request: cover property (quiet & wr_req2 & wdata_in[2] ##1 req_out[6:4] != 3'h0);
	c_tc_status:  cover property (tc_in[1] ##[1:8] rd_stat1);
	c_cascade:    cover property (quiet & wr_amsk2 & wdata_in[0] ##1 mask_q[4]);

endmodule : dmrs_top

// [pkg/dmrs_regs.svh]
// Register offsets, field positions and reset values of the
// request/mask/status block. Assumes an 8-bit I/O address space.
`ifndef DMRS_REGS_SVH
`define DMRS_REGS_SVH

// ==========================================================
// Offsets
`define DMRS_OFF_STAT1 8'h08
`define DMRS_OFF_REQ1  8'h09
`define DMRS_OFF_SMSK1 8'h0A
`define DMRS_OFF_AMSK1 8'h0F
`define DMRS_OFF_STAT2 8'hD0
`define DMRS_OFF_REQ2  8'hD2
`define DMRS_OFF_SMSK2 8'hD4
`define DMRS_OFF_AMSK2 8'hDE
`define DMRS_OFF_IST   8'h40
`define DMRS_OFF_IMSK  8'h41

// ==========================================================
// Fields
`define DMRS_SEL_MSB   1
`define DMRS_SEL_LSB   0
`define DMRS_SET_BIT   2

// ==========================================================
// Reset values
`define DMRS_MASK_RST  8'hFF
`define DMRS_TCS_RST   8'h00
`define DMRS_SWR_RST   8'h00
`define DMRS_IST_RST   8'h00
`define DMRS_IMSK_RST  8'h00
`define DMRS_RD_IDLE   8'h00

`endif

// [pkg/dmrs_pkg.sv]
// Types shared by the request/mask/status block.
// Assumes nothing of its surroundings.
package dmrs_pkg;
	typedef logic [7:0] dmrs_byte_t;
	typedef logic [3:0] dmrs_nib_t;
	typedef logic [1:0] dmrs_sel_t;
endpackage : dmrs_pkg

// [tb/dmrs_periph.sv]
// Model of expansion-bus devices raising request lines.
// Assumes the bench names the wanted lines and the answer lag.
// =====================================================
// Peripheral request model
module dmrs_periph (
	input  wire logic       clk_in,
	input  wire logic [7:0] want_in,
	input  wire logic [3:0] lag_in,
	output logic      [7:0] dreq_out
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [3:0] cnt_q = 4'h0;
	logic [7:0] lines_q = 8'h00;
	// Lines start idle low; one process owns them
	assign dreq_out = lines_q;
	// Slow devices wait lag cycles, so the bench sees late pins too
	always @(posedge clk_in) begin
		if (want_in == lines_q)
			cnt_q <= 4'h0;
		else if (cnt_q >= lag_in) begin
			lines_q <= want_in;
			cnt_q <= 4'h0;
		end else
			cnt_q <= cnt_q + 4'h1;
	end
endmodule : dmrs_periph

// [tb/dmrs_tb_top.sv]
// Self-checking bench of the request/mask/status block.
// Assumes one 10 MHz clock and the register offsets of the header.
`include "dmrs_regs.svh"
module dmrs_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic       clk_sys_in, rst_b_in, wr_in, rd_in, master_clear_in, irq_out;
	logic [7:0] addr_in, wdata_in, rdata_out, blk_timeout_in, tc_in;
	logic [7:0] autoinit_in, req_out, want, dreq;
	logic [3:0] lag;
	logic       clk_en;
	int         mismatches, n_tests;
	// =====================================================
	// Block and peripherals
	dmrs_top uut (.clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in), .clk_en_in(clk_en),
		.addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
		.rdata_out(rdata_out), .master_clear_in(master_clear_in), .dreq_in(dreq),
		.blk_timeout_in(blk_timeout_in), .tc_in(tc_in), .autoinit_in(autoinit_in),
		.req_out(req_out), .irq_out(irq_out));
	dmrs_periph u_periph (.clk_in(clk_sys_in), .want_in(want), .lag_in(lag),
		.dreq_out(dreq));
	// =====================================================
	// Shared tasks
	task automatic check(input logic [7:0] got, input logic [7:0] exp, input string msg);
		n_tests++;
		if (got !== exp) begin
			mismatches++;
			$display("unexpected at %0t: %s got %h exp %h", $time, msg, got, exp);
		end
	endtask : check
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys_in);
		addr_in <= a;
		wdata_in <= d;
		wr_in <= 1'b1;
		@(posedge clk_sys_in);
		wr_in <= 1'b0;
	endtask : wr
	// Read data stands only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string msg);
		@(posedge clk_sys_in);
		addr_in <= a;
		rd_in <= 1'b1;
		@(posedge clk_sys_in);
		rd_in <= 1'b0;
		#1 check(rdata_out, exp, msg);
	endtask : rd
	// Pins pass a two-stage synchroniser, so allow a bounded settle
	task automatic req_is(input logic [7:0] exp, input string msg);
		int i = 0;
		#1;
		while (req_out !== exp && i < 12) begin
			@(posedge clk_sys_in);
			#1;
			i++;
		end
		check(req_out, exp, msg);
	endtask : req_is
	task automatic irq_is(input logic exp, input string msg);
		#1 check({7'h00, irq_out}, {7'h00, exp}, msg);
	endtask : irq_is
	task automatic pulse_tc(input logic [7:0] v);
		@(posedge clk_sys_in);
		tc_in <= v;
		@(posedge clk_sys_in);
		tc_in <= 8'h00;
	endtask : pulse_tc
	// =====================================================
	// Scenarios
	task automatic t_reset;
		rd(`DMRS_OFF_AMSK1, 8'h0F, "mask1 rst");
		rd(`DMRS_OFF_AMSK2, 8'h0F, "mask2 rst");
		rd(`DMRS_OFF_STAT1, 8'h00, "stat1 rst");
		rd(`DMRS_OFF_REQ1, 8'h00, "wo read");
		rd(8'h55, 8'h00, "unmapped read");
		wr(8'h55, 8'hFF);
		req_is(8'h00, "req rst");
		irq_is(1'b0, "irq rst");
		$display("test reset done");
	endtask : t_reset
	// Every select code on both controllers, set then clear
	task automatic t_soft;
		logic [7:0] base, exp, st;
		for (int c = 0; c < 8; c++) begin
			base = (c < 4) ? `DMRS_OFF_REQ1 : `DMRS_OFF_REQ2;
			st = (c < 4) ? `DMRS_OFF_STAT1 : `DMRS_OFF_STAT2;
			wr(base, {5'h00, 1'b1, c[1:0]});
			exp = 8'h01 << c;
			exp[4] = exp[4] | (c < 4);
			req_is(exp, "soft req masked");
			rd(st, {4'h1 << c[1:0], 4'h0}, "soft pend");
			wr(base, {5'h00, 1'b0, c[1:0]});
			req_is(8'h00, "soft clr");
		end
		$display("test soft done");
	endtask : t_soft
	task automatic t_mask;
		@(posedge clk_sys_in);
		lag <= 4'h3;
		want <= 8'hEF;
		req_is(8'h00, "masked pins");
		wr(`DMRS_OFF_AMSK1, 8'h00);
		wr(`DMRS_OFF_AMSK2, 8'h00);
		req_is(8'hFF, "open");
		wr(`DMRS_OFF_SMSK1, 8'h06);
		req_is(8'hFB, "single mask");
		rd(`DMRS_OFF_AMSK1, 8'h04, "mask read");
		wr(`DMRS_OFF_SMSK2, 8'h04);
		req_is(8'hE0, "cascade mask");
		wr(`DMRS_OFF_SMSK2, 8'h00);
		wr(`DMRS_OFF_SMSK1, 8'h02);
		req_is(8'hFF, "unmask");
		wr(`DMRS_OFF_AMSK2, 8'h09);
		req_is(8'h60, "all mask 2");
		rd(`DMRS_OFF_AMSK2, 8'h09, "mask2 read");
		@(posedge clk_sys_in);
		want <= 8'h00;
		blk_timeout_in <= 8'h40;
		req_is(8'h40, "timeout req");
		rd(`DMRS_OFF_STAT2, 8'h40, "timeout pend");
		@(posedge clk_sys_in);
		blk_timeout_in <= 8'h00;
		$display("test mask done");
	endtask : t_mask
	task automatic t_tc;
		wr(`DMRS_OFF_AMSK1, 8'h00);
		wr(`DMRS_OFF_REQ1, 8'h05);
		wr(`DMRS_OFF_IMSK, 8'h02);
		autoinit_in <= 8'h20;
		pulse_tc(8'h22);
		req_is(8'h00, "tc clears soft");
		irq_is(1'b1, "irq on tc");
		rd(`DMRS_OFF_AMSK1, 8'h02, "tc sets mask");
		rd(`DMRS_OFF_AMSK2, 8'h09, "autoinit keeps mask");
		rd(`DMRS_OFF_STAT1, 8'h02, "tc flag");
		rd(`DMRS_OFF_STAT1, 8'h00, "tc flag read clr");
		rd(`DMRS_OFF_STAT2, 8'h02, "tc flag 2");
		wr(`DMRS_OFF_IMSK, 8'h00);
		irq_is(1'b0, "irq masked");
		wr(`DMRS_OFF_IMSK, 8'h02);
		irq_is(1'b1, "irq unmasked");
		wr(`DMRS_OFF_IST, 8'h22);
		irq_is(1'b0, "irq cleared");
		rd(`DMRS_OFF_IST, 8'h00, "ist cleared");
		$display("test tc done");
	endtask : t_tc
	task automatic t_clear;
		wr(`DMRS_OFF_REQ2, 8'h07);
		wr(`DMRS_OFF_AMSK2, 8'h00);
		@(posedge clk_sys_in);
		master_clear_in <= 1'b1;
		@(posedge clk_sys_in);
		master_clear_in <= 1'b0;
		req_is(8'h00, "mclr soft");
		rd(`DMRS_OFF_AMSK1, 8'h0F, "mclr mask1");
		rd(`DMRS_OFF_AMSK2, 8'h0F, "mclr mask2");
		wr(`DMRS_OFF_REQ1, 8'h04);
		req_is(8'h11, "soft again");
		// A write while the enable is low must leave all state frozen
		@(posedge clk_sys_in);
		clk_en <= 1'b0;
		wr(`DMRS_OFF_REQ1, 8'h05);
		@(posedge clk_sys_in);
		clk_en <= 1'b1;
		req_is(8'h11, "frozen write");
		@(posedge clk_sys_in);
		rst_b_in <= 1'b0;
		repeat (2) @(posedge clk_sys_in);
		rst_b_in <= 1'b1;
		req_is(8'h00, "reset soft");
		$display("test clear done");
	endtask : t_clear
	task automatic end_of_test;
		$display("checks %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : end_of_test
	// =====================================================
	// Clock, watchdog, main sequence
	initial begin
		clk_sys_in = 1'b0;
		forever #50 clk_sys_in = ~clk_sys_in;
	end
	// Whole run needs well under a thousand cycles
	initial begin
		repeat (20000) @(posedge clk_sys_in);
		mismatches++;
		end_of_test();
	end
	initial begin
		{rst_b_in, wr_in, rd_in, master_clear_in} = 4'h0;
		{addr_in, wdata_in, blk_timeout_in, tc_in, autoinit_in, want} = 48'h0;
		lag = 4'h0;
		clk_en = 1'b1;
		repeat (20) @(posedge clk_sys_in);
		rst_b_in <= 1'b1;
		t_reset();
		t_soft();
		t_mask();
		t_tc();
		t_clear();
		end_of_test();
	end
endmodule : dmrs_tb_top
